/* File: hw/sld_consts.svh */
`ifndef SLD_CONSTS_SVH
`define SLD_CONSTS_SVH
`define SLD_REG_W     128
`define SLD_DW_W      64
`define SLD_NUM_SIZES 4
`define SLD_F32_LANES 4
`define SLD_F32_SIGN  31
`define SLD_F32_EXPMX 8'hFF
`define SLD_F32_ALIGN 8'h18
`endif

/* File: hw/sld_pkg.sv */
package sld_pkg;
    typedef enum logic [4:0] {
        OP_ABS_DIFF_ACC, OP_ABS_DIFF_ACC_LONG, OP_ABS_DIFF, OP_ABS_DIFF_LONG,
        OP_LANE_MAG, OP_LANE_MAG_SAT, OP_LANE_SUM, OP_LANE_SUM_SAT, OP_LANE_SUM_LONG,
        OP_LANE_SUM_WIDE, OP_SUM_NARROW_UPPER, OP_LEAD_SIGN, OP_LEAD_ZERO, OP_POP_COUNT,
        OP_HALVING_SUM, OP_HALVING_DIFF, OP_LANE_MAX, OP_LANE_MIN
    } sld_op_e;
    typedef enum logic [1:0] {SZ8, SZ16, SZ32, SZ64} sld_size_e;
    typedef struct packed {
        logic          valid;
        sld_op_e       op;
        sld_size_e     size;
        logic          isUnsigned;
        logic          isFloat;
        logic          isQuad;
        logic          round;
        logic          condPass;
        logic [127:0]  srcA;
        logic [127:0]  srcB;
        logic [127:0]  srcD;
    } sld_req_s;
    typedef struct packed {
        logic          valid;
        logic          illegal;
        logic [127:0]  result;
    } sld_rsp_s;
endpackage : sld_pkg

/* File: hw/sld_datapath.sv */
`timescale 1ns/100ps
`include "sld_consts.svh"
module sld_datapath (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire sld_pkg::sld_req_s req,
    input  wire logic             satFlagClear,
    output sld_pkg::sld_rsp_s     rsp,
    output logic                  satFlag
);
////////////////////////////////////////////////////////////////////////////////
    // float add with truncation; denormal results flush to zero, no inf or nan handling
    function automatic logic [31:0] fAdd(input logic [31:0] x, input logic [31:0] y);
        logic [31:0] p;
        logic [31:0] q;
        logic [7:0]  sh;
        logic [24:0] m;
        logic [24:0] mq;
        logic [8:0]  e;
        if (x[30:0] >= y[30:0]) begin
            p = x;
            q = y;
        end else begin
            p = y;
            q = x;
        end
        sh = p[30:23] - q[30:23];
        mq = (sh > `SLD_F32_ALIGN) ? 25'h0000000 : ({1'b0, q[30:23] != 8'h00, q[22:0]} >> sh);
        if (p[31] == q[31]) begin
            m = {1'b0, p[30:23] != 8'h00, p[22:0]} + mq;
        end else begin
            m = {1'b0, p[30:23] != 8'h00, p[22:0]} - mq;
        end
        e = {1'b0, p[30:23]};
        if (m[24]) begin
            m = m >> 1;
            e = e + 9'h001;
        end else begin
            for (int j = 0; j < 24; j++) begin
                if (m != 25'h0000000 && !m[23] && e != 9'h000) begin
                    m = m << 1;
                    e = e - 9'h001;
                end
            end
        end
        if (m == 25'h0000000 || e == 9'h000) begin
            fAdd = 32'h00000000;
        end else if (e >= {1'b0, `SLD_F32_EXPMX}) begin
            fAdd = {p[31], `SLD_F32_EXPMX, 23'h000000};
        end else begin
            fAdd = {p[31], e[7:0], m[22:0]};
        end
    endfunction : fAdd

    // maps a float onto an unsigned key so integer compare orders it
    function automatic logic [31:0] fKey(input logic [31:0] x);
        fKey = x[31] ? ~x : (x | 32'h80000000);
    endfunction : fKey

////////////////////////////////////////////////////////////////////////////////
    logic [127:0] stdRes    [`SLD_NUM_SIZES];
    logic [127:0] longRes   [`SLD_NUM_SIZES];
    logic [63:0]  narrowRes [`SLD_NUM_SIZES];
    logic         satAny    [`SLD_NUM_SIZES];
    logic         sgn;
    assign sgn = ~req.isUnsigned;

    genvar g, i;
    for (g = 0; g < `SLD_NUM_SIZES; g++) begin : g_size
        localparam int W = 8 << g;
        localparam int N = `SLD_REG_W / W;
        logic [127:0] resG;
        logic [N-1:0] satL;
        logic [N-1:0] actL;
        for (i = 0; i < N; i++) begin : g_lane
            logic [W-1:0] a;
            logic [W-1:0] b;
            logic [W-1:0] d;
            logic [W-1:0] r;
            logic [W-1:0] mag;
            logic [W-1:0] aNeg;
            logic [W:0]   ax;
            logic [W:0]   bx;
            logic [W:0]   sum;
            logic [W:0]   sumR;
            logic [W:0]   diff;
            logic         ovf;
            logic [7:0]   cntLz;
            logic [7:0]   cntLs;
            logic [7:0]   cntOn;
            assign a    = req.srcA[i*W +: W];
            assign b    = req.srcB[i*W +: W];
            assign d    = req.srcD[i*W +: W];
            assign ax   = {sgn & a[W-1], a};
            assign bx   = {sgn & b[W-1], b};
            // one spare bit per lane keeps carries inside the lane
            assign sum  = ax + bx;
            assign sumR = sum + {{W{1'b0}}, req.round};
            assign diff = ax - bx;
            assign mag  = diff[W] ? W'(~diff + 1'b1) : diff[W-1:0];
            assign aNeg = W'(~a + 1'b1);
            assign ovf  = sgn ? (sum[W] ^ sum[W-1]) : sum[W];
            assign actL[i] = req.isQuad || (i < N / 2);
            always_comb begin
                logic stopZ;
                logic stopS;
                stopZ = 1'b0;
                stopS = 1'b0;
                cntLz = 8'h00;
                cntLs = 8'h00;
                cntOn = 8'h00;
                for (int k = W - 1; k >= 0; k--) begin
                    if (!stopZ && !a[k]) cntLz = cntLz + 8'h01;
                    else stopZ = 1'b1;
                    cntOn = cntOn + {7'h00, a[k]};
                end
                for (int k = W - 2; k >= 0; k--) begin
                    if (!stopS && a[k] == a[W-1]) cntLs = cntLs + 8'h01;
                    else stopS = 1'b1;
                end
            end
            always_comb begin
                r = d;
                satL[i] = 1'b0;
                unique case (req.op)
                    sld_pkg::OP_ABS_DIFF:     r = mag;
                    sld_pkg::OP_ABS_DIFF_ACC: r = d + mag;
                    sld_pkg::OP_LANE_MAG:     r = a[W-1] ? aNeg : a;
                    sld_pkg::OP_LANE_MAG_SAT: begin
                        r = a[W-1] ? aNeg : a;
                        if (a == {1'b1, {(W-1){1'b0}}}) begin
                            r = {1'b0, {(W-1){1'b1}}};
                            satL[i] = 1'b1;
                        end
                    end
                    sld_pkg::OP_LANE_SUM:     r = sum[W-1:0];
                    sld_pkg::OP_LANE_SUM_SAT: begin
                        r = sum[W-1:0];
                        if (ovf) begin
                            r = sgn ? {sum[W], {(W-1){~sum[W]}}} : {W{1'b1}};
                            satL[i] = 1'b1;
                        end
                    end
                    sld_pkg::OP_HALVING_SUM:  r = sumR[W:1];
                    sld_pkg::OP_HALVING_DIFF: r = diff[W:1];
                    sld_pkg::OP_LANE_MAX:     r = diff[W] ? b : a;
                    sld_pkg::OP_LANE_MIN:     r = diff[W] ? a : b;
                    sld_pkg::OP_LEAD_SIGN:    r = W'(cntLs);
                    sld_pkg::OP_LEAD_ZERO:    r = W'(cntLz);
                    sld_pkg::OP_POP_COUNT:    r = W'(cntOn);
                    default:                  r = d;
                endcase
            end
            assign resG[i*W +: W] = r;
        end
        assign stdRes[g] = resG;
        // upper lanes of a doubleword form must not raise the flag
        assign satAny[g] = |(satL & actL);

        if (g < `SLD_NUM_SIZES - 1) begin : g_long
            logic [127:0] resL;
            for (i = 0; i < `SLD_DW_W / W; i++) begin : g_ll
                logic [2*W-1:0] lax;
                logic [2*W-1:0] lbx;
                logic [2*W-1:0] ldf;
                logic [2*W-1:0] lmag;
                logic [2*W-1:0] ld;
                logic [2*W-1:0] lr;
                assign lax  = {{W{sgn & req.srcA[i*W+W-1]}}, req.srcA[i*W +: W]};
                assign lbx  = {{W{sgn & req.srcB[i*W+W-1]}}, req.srcB[i*W +: W]};
                assign ld   = req.srcD[i*2*W +: 2*W];
                assign ldf  = lax - lbx;
                assign lmag = ldf[2*W-1] ? (~ldf + 1'b1) : ldf;
                always_comb begin
                    unique case (req.op)
                        sld_pkg::OP_ABS_DIFF_LONG:     lr = lmag;
                        sld_pkg::OP_ABS_DIFF_ACC_LONG: lr = ld + lmag;
                        sld_pkg::OP_LANE_SUM_LONG:     lr = lax + lbx;
                        sld_pkg::OP_LANE_SUM_WIDE:     lr = req.srcA[i*2*W +: 2*W] + lbx;
                        default:                       lr = ld;
                    endcase
                end
                assign resL[i*2*W +: 2*W] = lr;
            end
            assign longRes[g] = resL;
        end else begin : g_nolong
            assign longRes[g] = req.srcD;
        end

        if (g > 0) begin : g_narrow
            localparam int H = W / 2;
            logic [63:0] resN;
            for (i = 0; i < N; i++) begin : g_nl
                logic [W-1:0] ns;
                // rounding adds half of the dropped part before truncation
                assign ns = req.srcA[i*W +: W] + req.srcB[i*W +: W]
                          + ({{(W-1){1'b0}}, req.round} << (H - 1));
                assign resN[i*H +: H] = ns[W-1:H];
            end
            assign narrowRes[g] = resN;
        end else begin : g_nonarrow
            assign narrowRes[g] = req.srcD[63:0];
        end
    end

////////////////////////////////////////////////////////////////////////////////
    logic [127:0] fRes;
    for (i = 0; i < `SLD_F32_LANES; i++) begin : g_flt
        logic [31:0] fa;
        logic [31:0] fb;
        logic [31:0] fs;
        logic [31:0] fd;
        logic        fGt;
        assign fa  = req.srcA[i*32 +: 32];
        assign fb  = req.srcB[i*32 +: 32];
        assign fs  = fAdd(fa, fb);
        assign fd  = fAdd(fa, fb ^ 32'h80000000);
        assign fGt = fKey(fa) >= fKey(fb);
        always_comb begin
            unique case (req.op)
                sld_pkg::OP_LANE_MAG: fRes[i*32 +: 32] = {1'b0, fa[30:0]};
                sld_pkg::OP_LANE_SUM: fRes[i*32 +: 32] = fs;
                sld_pkg::OP_ABS_DIFF: fRes[i*32 +: 32] = {1'b0, fd[30:0]};
                sld_pkg::OP_LANE_MAX: fRes[i*32 +: 32] = fGt ? fa : fb;
                sld_pkg::OP_LANE_MIN: fRes[i*32 +: 32] = fGt ? fb : fa;
                default:              fRes[i*32 +: 32] = req.srcD[i*32 +: 32];
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////////
    logic         legal;
    logic         isLong;
    logic         isNarrow;
    logic [127:0] resD;
    logic         satHit;
    always_comb begin
        isLong   = req.op inside {sld_pkg::OP_ABS_DIFF_ACC_LONG, sld_pkg::OP_ABS_DIFF_LONG,
                                  sld_pkg::OP_LANE_SUM_LONG, sld_pkg::OP_LANE_SUM_WIDE};
        isNarrow = req.op == sld_pkg::OP_SUM_NARROW_UPPER;
        if (req.isFloat) begin
            legal = (req.size == sld_pkg::SZ32) && (req.op inside {sld_pkg::OP_ABS_DIFF,
                    sld_pkg::OP_LANE_MAG, sld_pkg::OP_LANE_SUM, sld_pkg::OP_LANE_MAX, sld_pkg::OP_LANE_MIN});
        end else begin
            unique case (req.op)
                sld_pkg::OP_POP_COUNT:        legal = req.size == sld_pkg::SZ8;
                sld_pkg::OP_SUM_NARROW_UPPER: legal = req.size != sld_pkg::SZ8;
                sld_pkg::OP_LANE_SUM,
                sld_pkg::OP_LANE_SUM_SAT:     legal = 1'b1;
                sld_pkg::OP_LANE_MAG,
                sld_pkg::OP_LANE_MAG_SAT,
                sld_pkg::OP_LEAD_SIGN:        legal = sgn && req.size != sld_pkg::SZ64;
                default:                      legal = req.size != sld_pkg::SZ64;
            endcase
        end
    end

    always_comb begin
        resD   = req.srcD;
        satHit = 1'b0;
        if (legal && req.condPass) begin
            if (isLong) begin
                resD = longRes[req.size];
            end else if (isNarrow) begin
                resD = {req.srcD[127:64], narrowRes[req.size]};
            end else begin
                resD = req.isFloat ? fRes : stdRes[req.size];
                // doubleword form leaves the upper half of the register alone
                if (!req.isQuad) resD = {req.srcD[127:64], resD[63:0]};
                satHit = !req.isFloat && satAny[req.size];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp <= '0;
        end else begin
            rsp.valid   <= req.valid;
            rsp.illegal <= req.valid && !legal;
            if (req.valid) rsp.result <= resD;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            satFlag <= 1'b0;
        end else if (req.valid && satHit) begin
            satFlag <= 1'b1;
        end else if (satFlagClear) begin
            satFlag <= 1'b0;
        end
    end
endmodule : sld_datapath

/* File: test/sld_monitor.sv */
`timescale 1ns/100ps
module sld_monitor (
    input wire logic              sys_clk,
    input wire logic              srst,
    input wire sld_pkg::sld_req_s req,
    input wire logic              satFlagClear,
    input wire sld_pkg::sld_rsp_s rsp,
    input wire logic              satFlag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    a_rsp_one_cycle: assert property (req.valid |=> rsp.valid)
        else $error("response missing one cycle after issue");
    a_no_stray_rsp: assert property (!req.valid |=> !rsp.valid && !rsp.illegal)
        else $error("response without an issue");
    a_cond_keeps_dest: assert property (req.valid && !req.condPass |=> rsp.result == $past(req.srcD))
        else $error("failed condition changed the destination");
    a_pop_wide_refused: assert property (req.valid && req.condPass && req.op == sld_pkg::OP_POP_COUNT
        && req.size != sld_pkg::SZ8 |=> rsp.illegal && rsp.result == $past(req.srcD))
        else $error("population count accepted a wide lane");
    // doubleword form of a lane add must leave the upper half of the destination alone
    a_dword_upper_kept: assert property (req.valid && req.op == sld_pkg::OP_LANE_SUM && !req.isQuad
        |=> rsp.result[127:64] == $past(req.srcD[127:64]))
        else $error("doubleword add touched the upper half");
    a_mag_float_sign: assert property (req.valid && req.condPass && req.isQuad && req.isFloat
        && !req.isUnsigned && req.size == sld_pkg::SZ32 && req.op == sld_pkg::OP_LANE_MAG
        |=> rsp.result == ($past(req.srcA) & ~{4{32'h80000000}}))
        else $error("float magnitude changed more than the sign");
    a_flag_sticky: assert property (satFlag && !satFlagClear |=> satFlag)
        else $error("saturation flag dropped without a clear");
    a_flag_clears: assert property (satFlagClear && !req.valid |=> !satFlag)
        else $error("saturation flag ignored the clear");
    a_flag_cause: assert property ($rose(satFlag) |-> $past(req.valid)
        && ($past(req.op) == sld_pkg::OP_LANE_SUM_SAT || $past(req.op) == sld_pkg::OP_LANE_MAG_SAT))
        else $error("saturation flag set by a non-saturating op");
    c_sat_set: cover property ($rose(satFlag));
    c_cond_fail: cover property (req.valid && !req.condPass);
    c_refused: cover property (rsp.illegal);
    c_set_with_clear: cover property (req.valid && satFlagClear ##1 satFlag);
endmodule : sld_monitor
bind sld_datapath sld_monitor u_sld_monitor (.sys_clk(sys_clk), .srst(srst), .req(req),
    .satFlagClear(satFlagClear), .rsp(rsp), .satFlag(satFlag));

/* File: test/sld_vreg_model.sv */
`timescale 1ns/100ps
// register file side: takes each written-back result, counts write-backs
module sld_vreg_model (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire sld_pkg::sld_rsp_s rsp,
    output logic [127:0]           destReg_q,
    output logic [15:0]            writeCount_q
);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            destReg_q    <= 128'h0;
            writeCount_q <= 16'h0;
        end else if (rsp.valid) begin
            destReg_q    <= rsp.result;
            writeCount_q <= writeCount_q + 16'h1;
        end
    end
endmodule : sld_vreg_model

/* File: test/sld_datapath_tb_top.sv */
`timescale 1ns/100ps
module sld_datapath_tb_top;
    logic              sys_clk;
    logic              srst;
    logic              satFlagClear;
    logic              satFlag;
    sld_pkg::sld_req_s req;
    sld_pkg::sld_rsp_s rsp;
    logic [127:0]      destReg;
    logic [15:0]       writeCount;
    int                errTotal;
    int                checkCount;
    int                issued;
    sld_datapath u_sld_datapath (.sys_clk(sys_clk), .srst(srst), .req(req), .satFlagClear(satFlagClear),
        .rsp(rsp), .satFlag(satFlag));
    sld_vreg_model u_sld_vreg_model (.sys_clk(sys_clk), .srst(srst), .rsp(rsp), .destReg_q(destReg),
        .writeCount_q(writeCount));
    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : printVerdict
    task automatic cmp128(input logic [127:0] got, input logic [127:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp128
    task automatic cmp1(input logic got, input logic exp);
        cmp128({127'h0, got}, {127'h0, exp});
    endtask : cmp1
    // fl = {unsigned, float, quad, round, condPass}
    task automatic issue(input sld_pkg::sld_op_e op, input sld_pkg::sld_size_e sz, input logic [4:0] fl,
        input logic [127:0] a, input logic [127:0] b, input logic [127:0] d, input logic [127:0] exp,
        input logic ill);
        int n;
        req = '{valid: 1'h1, op: op, size: sz, isUnsigned: fl[4], isFloat: fl[3], isQuad: fl[2],
                round: fl[1], condPass: fl[0], srcA: a, srcB: b, srcD: d};
        @(posedge sys_clk);
        #1 req.valid = 1'h0;
        issued++;
        n = 0;
        while (rsp.valid !== 1'h1 && n < 4) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n == 4) begin
            errTotal++;
            printVerdict();
        end
        cmp128(rsp.result, exp);
        cmp1(rsp.illegal, ill);
        // one idle edge between requests keeps valid from being lowered and raised in one step
        @(posedge sys_clk);
        #1 cmp1(rsp.valid, 1'h0);
        cmp128(destReg, exp);
    endtask : issue
    ////////////////////////////////////////////////////////////////////////////////
    task automatic s_sum;
        issue(sld_pkg::OP_LANE_SUM, sld_pkg::SZ8, 5'h05, {16{8'hFF}}, {16{8'h01}}, 128'h0, 128'h0, 1'h0);
        issue(sld_pkg::OP_LANE_SUM, sld_pkg::SZ64, 5'h01, {2{64'h1}}, {2{64'h2}}, {128{1'h1}},
            {{64{1'h1}}, 64'h3}, 1'h0);
        issue(sld_pkg::OP_LANE_SUM, sld_pkg::SZ32, 5'h0D, {4{32'h3F800000}}, {4{32'h3F800000}}, 128'h0,
            {4{32'h40000000}}, 1'h0);
        issue(sld_pkg::OP_LANE_SUM_SAT, sld_pkg::SZ8, 5'h05, {16{8'h7F}}, {16{8'h01}}, 128'h0, {16{8'h7F}}, 1'h0);
        cmp1(satFlag, 1'h1);
        issue(sld_pkg::OP_LANE_SUM_SAT, sld_pkg::SZ64, 5'h15, {2{64'hFFFFFFFFFFFFFFFF}}, {2{64'h1}}, 128'h0,
            {128{1'h1}}, 1'h0);
        issue(sld_pkg::OP_LANE_SUM, sld_pkg::SZ8, 5'h04, {16{8'h01}}, {16{8'h01}}, {16{8'hA5}}, {16{8'hA5}}, 1'h0);
        cmp1(satFlag, 1'h1);
        satFlagClear = 1'h1;
        @(posedge sys_clk);
        #1 satFlagClear = 1'h0;
        cmp1(satFlag, 1'h0);
        // upper lanes overflow but only the low half is live in doubleword form
        issue(sld_pkg::OP_LANE_SUM_SAT, sld_pkg::SZ8, 5'h01, {{8{8'h7F}}, {8{8'h00}}}, {16{8'h01}}, 128'h0,
            {64'h0, {8{8'h01}}}, 1'h0);
        cmp1(satFlag, 1'h0);
    endtask : s_sum
    task automatic s_wide;
        issue(sld_pkg::OP_LANE_SUM_WIDE, sld_pkg::SZ8, 5'h11, {8{16'h00FF}}, {64'h0, {8{8'h01}}}, 128'h0,
            {8{16'h0100}}, 1'h0);
        issue(sld_pkg::OP_LANE_SUM_LONG, sld_pkg::SZ8, 5'h01, {8{8'hFF}}, {8{8'hFF}}, 128'h0, {8{16'hFFFE}}, 1'h0);
        issue(sld_pkg::OP_SUM_NARROW_UPPER, sld_pkg::SZ16, 5'h05, {8{16'h1280}}, 128'h0, {128{1'h1}},
            {{64{1'h1}}, {8{8'h12}}}, 1'h0);
        issue(sld_pkg::OP_SUM_NARROW_UPPER, sld_pkg::SZ16, 5'h07, {8{16'h1280}}, 128'h0, {128{1'h1}},
            {{64{1'h1}}, {8{8'h13}}}, 1'h0);
        issue(sld_pkg::OP_SUM_NARROW_UPPER, sld_pkg::SZ8, 5'h05, {16{8'h11}}, 128'h0, {16{8'h3C}}, {16{8'h3C}}, 1'h1);
    endtask : s_wide
    task automatic s_diff;
        issue(sld_pkg::OP_ABS_DIFF, sld_pkg::SZ8, 5'h15, {16{8'h01}}, {16{8'hFF}}, 128'h0, {16{8'hFE}}, 1'h0);
        issue(sld_pkg::OP_ABS_DIFF, sld_pkg::SZ8, 5'h05, {16{8'h01}}, {16{8'hFF}}, 128'h0, {16{8'h02}}, 1'h0);
        issue(sld_pkg::OP_ABS_DIFF, sld_pkg::SZ32, 5'h0D, {4{32'h3F800000}}, {4{32'h40400000}}, 128'h0,
            {4{32'h40000000}}, 1'h0);
        issue(sld_pkg::OP_ABS_DIFF_ACC, sld_pkg::SZ8, 5'h05, {16{8'h01}}, {16{8'hFF}}, {16{8'h10}}, {16{8'h12}}, 1'h0);
        issue(sld_pkg::OP_ABS_DIFF_ACC, sld_pkg::SZ32, 5'h15, {4{32'h1}}, {4{32'h3}}, {4{32'h5}}, {4{32'h7}}, 1'h0);
        issue(sld_pkg::OP_ABS_DIFF_LONG, sld_pkg::SZ8, 5'h01, {8{8'h01}}, {8{8'hFF}}, 128'h0, {8{16'h0002}}, 1'h0);
        issue(sld_pkg::OP_ABS_DIFF_ACC_LONG, sld_pkg::SZ8, 5'h11, 128'h0, {8{8'hFF}}, {8{16'h0001}},
            {8{16'h0100}}, 1'h0);
        issue(sld_pkg::OP_ABS_DIFF_LONG, sld_pkg::SZ32, 5'h09, {4{32'h1}}, 128'h0, {16{8'h5A}}, {16{8'h5A}}, 1'h1);
    endtask : s_diff
    task automatic s_mag;
        issue(sld_pkg::OP_LANE_MAG, sld_pkg::SZ16, 5'h05, {8{16'hFFFF}}, 128'h0, 128'h0, {8{16'h0001}}, 1'h0);
        issue(sld_pkg::OP_LANE_MAG, sld_pkg::SZ32, 5'h0D, {4{32'hBF800001}}, 128'h0, 128'h0,
            {4{32'h3F800001}}, 1'h0);
        issue(sld_pkg::OP_LANE_MAG_SAT, sld_pkg::SZ8, 5'h05, {16{8'h80}}, 128'h0, 128'h0, {16{8'h7F}}, 1'h0);
        cmp1(satFlag, 1'h1);
        // saturation and clear in the same cycle: the set must win
        req = '{valid: 1'h1, op: sld_pkg::OP_LANE_MAG_SAT, size: sld_pkg::SZ8, isUnsigned: 1'h0, isFloat: 1'h0,
                isQuad: 1'h1, round: 1'h0, condPass: 1'h1, srcA: {16{8'h80}}, srcB: 128'h0, srcD: 128'h0};
        satFlagClear = 1'h1;
        @(posedge sys_clk);
        #1 req.valid = 1'h0;
        satFlagClear = 1'h0;
        issued++;
        cmp1(satFlag, 1'h1);
        cmp128(rsp.result, {16{8'h7F}});
        @(posedge sys_clk);
        #1 cmp1(rsp.valid, 1'h0);
    endtask : s_mag
    task automatic s_count;
        issue(sld_pkg::OP_LEAD_SIGN, sld_pkg::SZ8, 5'h05, {16{8'h0F}}, 128'h0, 128'h0, {16{8'h03}}, 1'h0);
        issue(sld_pkg::OP_LEAD_ZERO, sld_pkg::SZ32, 5'h05, {4{32'h00010000}}, 128'h0, 128'h0, {4{32'hF}}, 1'h0);
        issue(sld_pkg::OP_POP_COUNT, sld_pkg::SZ8, 5'h05, {16{8'hF1}}, 128'h0, 128'h0, {16{8'h05}}, 1'h0);
        issue(sld_pkg::OP_POP_COUNT, sld_pkg::SZ16, 5'h05, {16{8'hF1}}, 128'h0, {16{8'h77}}, {16{8'h77}}, 1'h1);
    endtask : s_count
    task automatic s_half;
        issue(sld_pkg::OP_HALVING_SUM, sld_pkg::SZ8, 5'h05, {16{8'h7F}}, {16{8'h7F}}, 128'h0, {16{8'h7F}}, 1'h0);
        issue(sld_pkg::OP_HALVING_SUM, sld_pkg::SZ32, 5'h15, {4{32'h1}}, {4{32'h2}}, 128'h0, {4{32'h1}}, 1'h0);
        issue(sld_pkg::OP_HALVING_SUM, sld_pkg::SZ32, 5'h17, {4{32'h1}}, {4{32'h2}}, 128'h0, {4{32'h2}}, 1'h0);
        issue(sld_pkg::OP_HALVING_DIFF, sld_pkg::SZ16, 5'h17, {8{16'h3}}, 128'h0, 128'h0, {8{16'h1}}, 1'h0);
        issue(sld_pkg::OP_HALVING_DIFF, sld_pkg::SZ16, 5'h05, 128'h0, {8{16'h1}}, 128'h0, {8{16'hFFFF}}, 1'h0);
    endtask : s_half
    task automatic s_maxmin;
        issue(sld_pkg::OP_LANE_MAX, sld_pkg::SZ8, 5'h15, {16{8'h80}}, {16{8'h7F}}, 128'h0, {16{8'h80}}, 1'h0);
        issue(sld_pkg::OP_LANE_MAX, sld_pkg::SZ8, 5'h05, {16{8'h80}}, {16{8'h7F}}, 128'h0, {16{8'h7F}}, 1'h0);
        issue(sld_pkg::OP_LANE_MIN, sld_pkg::SZ8, 5'h05, {16{8'h7F}}, {16{8'h80}}, 128'h0, {16{8'h80}}, 1'h0);
        issue(sld_pkg::OP_LANE_MAX, sld_pkg::SZ32, 5'h0D, {4{32'hBF800000}}, {4{32'h3F800000}}, 128'h0,
            {4{32'h3F800000}}, 1'h0);
        issue(sld_pkg::OP_LANE_MIN, sld_pkg::SZ32, 5'h0D, {4{32'h3F800000}}, {4{32'hBF800000}}, 128'h0,
            {4{32'hBF800000}}, 1'h0);
    endtask : s_maxmin
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        errTotal = 0;
        checkCount = 0;
        issued = 0;
        srst = 1'h1;
        satFlagClear = 1'h0;
        req = '0;
        repeat (10) @(posedge sys_clk);
        #1 srst = 1'h0;
        cmp1(satFlag, 1'h0);
        s_sum();
        s_wide();
        s_diff();
        s_mag();
        s_count();
        s_half();
        s_maxmin();
        @(posedge sys_clk);
        #1 cmp128({112'h0, writeCount}, 128'(issued));
        printVerdict();
    end
endmodule : sld_datapath_tb_top
